// >>> hw/plcbc_pkg.sv
// Behaviour
// - rotate right one bit wraps lsb to msb, carry takes the wrapped bit
// - rotate left one bit wraps msb to lsb, carry takes the wrapped bit
// - rotate right by n into destination, carry from last wrapped bit
// - rotate left by n into destination, carry from last wrapped bit
// - six signed word compares drive rung output when relation holds
// - six double-word compares on upper:lower 32-bit signed operands
// - six unsigned word compares drive rung output when relation holds
// - set turns device on, or loads word register with all ones
// - reset turns device off, or loads word register with zero
// - set-carry forces carry to one, operands untouched
// - clear-carry forces carry to zero, operands untouched
// - encode writes position of highest set bit within 2^n field
// - decode sets only the bit chosen by low n source bits
// - bit count stores number of one bits of source
// - latch on with set input, off with clear input, clear wins
// - counter steps once per count activation only while enabled
// - counter counts up when direction active, down when inactive
package plcbc_pkg;

    localparam int unsigned WORD_W  = 16;
    localparam int unsigned DWORD_W = 32;
    localparam int unsigned SHAM_W  = 4;
    localparam int unsigned FIELD_N_W = 3;
    localparam int unsigned CNT_W   = 5;

    localparam logic [WORD_W-1:0] WORD_ONES = 16'hffff;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

    // instruction codes, decimal numbers held as hex values
    localparam logic [7:0] OP_ROR1    = 8'h4e; // 078
    localparam logic [7:0] OP_ROL1    = 8'h4f; // 079
    localparam logic [7:0] OP_RORN    = 8'h50; // 080
    localparam logic [7:0] OP_ROLN    = 8'h51; // 081
    localparam logic [7:0] OP_CMP_S   = 8'h60; // 096..101
    localparam logic [7:0] OP_CMP_D   = 8'h66; // 102..107
    localparam logic [7:0] OP_CMP_U   = 8'h6c; // 108..113
    localparam logic [7:0] OP_SET     = 8'h72; // 114
    localparam logic [7:0] OP_RST     = 8'h73; // 115
    localparam logic [7:0] OP_CARRY_ON  = 8'h74;
    localparam logic [7:0] OP_CARRY_OFF = 8'h75;
    localparam logic [7:0] OP_ENCODE  = 8'h78; // 120
    localparam logic [7:0] OP_DECODE  = 8'h79; // 121
    localparam logic [7:0] OP_POPCNT  = 8'h7a; // 122
    localparam logic [7:0] OP_FF      = 8'h93; // 147
    localparam logic [7:0] OP_UDC     = 8'h95; // 149
    localparam logic [2:0] CMP_SPAN   = 3'h6;

    // relation index within a compare group
    typedef enum logic [2:0]
    {
        PLCBC_GT,
        PLCBC_GE,
        PLCBC_EQ,
        PLCBC_NE,
        PLCBC_LT,
        PLCBC_LE
    } plcbc_rel_e;

endpackage

// >>> hw/plcbc_popcount.sv
`timescale 1ns/100ps
`default_nettype none
module plcbc_popcount
#(
    parameter int unsigned W   = 16,
    parameter int unsigned CW  = 5
)
(
    // operand and count
    input  wire logic [W-1:0]  word,
    output logic      [CW-1:0] ones
);
    import plcbc_pkg::*;

    // ===================================================
    // bit count
    // ===================================================
    // sum of ones
    always_comb
    begin
        ones = '0;
        for (int i = 0; i < W; i++)
        begin
            ones = ones + CW'(word[i]);
        end
    end
endmodule
`default_nettype wire

// >>> hw/plcbc_datapath.sv
`timescale 1ns/100ps
`default_nettype none
module plcbc_datapath
(
    // clock and reset
    input  wire logic                            mclk,
    input  wire logic                            reset_n,
    // instruction issue
    input  wire logic                            op_valid,
    input  wire logic [7:0]                      instruction_code,
    input  wire logic                            rung_in,
    input  wire logic                            operand_is_word,
    // operands
    input  wire logic [plcbc_pkg::WORD_W-1:0]    src_lo,
    input  wire logic [plcbc_pkg::WORD_W-1:0]    src_hi,
    input  wire logic [plcbc_pkg::WORD_W-1:0]    ref_lo,
    input  wire logic [plcbc_pkg::WORD_W-1:0]    ref_hi,
    input  wire logic [plcbc_pkg::SHAM_W-1:0]    rot_count,
    input  wire logic [plcbc_pkg::FIELD_N_W-1:0] field_n,
    // latch and counter inputs
    input  wire logic                            ff_set_in,
    input  wire logic                            ff_clr_in,
    input  wire logic                            cnt_enable,
    input  wire logic                            cnt_pulse_in,
    input  wire logic                            cnt_up,
    // results
    output logic                                 done,
    output logic                                 result_we,
    output logic [plcbc_pkg::WORD_W-1:0]         result_word,
    output logic                                 device_we,
    output logic                                 device_val,
    output logic                                 rung_out,
    output logic                                 carry,
    output logic [plcbc_pkg::WORD_W-1:0]         count_val
);
    import plcbc_pkg::*;

    // ===================================================
    // state
    // ===================================================
    typedef struct packed
    {
        logic              done;
        logic              result_we;
        logic [WORD_W-1:0] result_word;
        logic              device_we;
        logic              device_val;
        logic              rung_out;
        logic              carry;
        logic [WORD_W-1:0] count_val;
        logic              pulse_prev;
    } plcbc_state_s;

    plcbc_state_s st_q;
    plcbc_state_s st_d;

    // ===================================================
    // combinational helpers
    // ===================================================
    logic [CNT_W-1:0]  pop_ones;
    logic [WORD_W-1:0] ror_n;
    logic [WORD_W-1:0] rol_n;
    logic [WORD_W-1:0] top_bit_pos;
    logic [WORD_W-1:0] one_hot_word;
    logic [WORD_W-1:0] field_mask;
    logic              rel_gt;
    logic              rel_eq;
    logic              rel_lt;
    logic [2:0]        rel_idx;
    logic              rel_hit;
    logic [DWORD_W-1:0] d_a;
    logic [DWORD_W-1:0] d_b;

    plcbc_popcount
    #(
        .W  (WORD_W),
        .CW (CNT_W)
    )
    i_plcbc_popcount
    (
        .word (src_lo),
        .ones (pop_ones)
    );

    assign d_a = {src_hi, src_lo};
    assign d_b = {ref_hi, ref_lo};

    // rotations by n, doubled word trick avoids a barrel mux tree
    always_comb
    begin
        ror_n = WORD_W'({src_lo, src_lo} >> rot_count);
        rol_n = WORD_W'(({src_lo, src_lo} << rot_count) >> WORD_W);
    end

    // field mask for 2^n bits, limited to one word
    always_comb
    begin
        field_mask = WORD_ZERO;
        for (int i = 0; i < WORD_W; i++)
        begin
            if (i < (1 << field_n))
            begin
                field_mask[i] = 1'b1;
            end
        end
    end

    always_comb
    begin
        top_bit_pos = WORD_ZERO;
        for (int i = 0; i < WORD_W; i++)
        begin
            if (src_lo[i] && field_mask[i])
            begin
                top_bit_pos = WORD_W'(i);
            end
        end
    end

    always_comb
    begin
        one_hot_word = WORD_ZERO;
        for (int i = 0; i < WORD_W; i++)
        begin
            // only the low n source bits pick the position
            if ((WORD_W'(i) == (src_lo & WORD_W'((1 << field_n) - 1)))
                && field_mask[i])
            begin
                one_hot_word[i] = 1'b1;
            end
        end
    end

    // relations per compare group
    always_comb
    begin
        rel_gt  = 1'b0;
        rel_eq  = 1'b0;
        rel_lt  = 1'b0;
        rel_idx = 3'h0;
        if (instruction_code >= OP_CMP_U)
        begin
            rel_gt  = src_lo > ref_lo;
            rel_lt  = src_lo < ref_lo;
            rel_eq  = src_lo == ref_lo;
            rel_idx = 3'(instruction_code - OP_CMP_U);
        end
        else if (instruction_code >= OP_CMP_D)
        begin
            rel_gt  = $signed(d_a) > $signed(d_b);
            rel_lt  = $signed(d_a) < $signed(d_b);
            rel_eq  = d_a == d_b;
            rel_idx = 3'(instruction_code - OP_CMP_D);
        end
        else
        begin
            rel_gt  = $signed(src_lo) > $signed(ref_lo);
            rel_lt  = $signed(src_lo) < $signed(ref_lo);
            rel_eq  = src_lo == ref_lo;
            rel_idx = 3'(instruction_code - OP_CMP_S);
        end
    end

    // pick relation by index
    always_comb
    begin
        case (plcbc_rel_e'(rel_idx))
            PLCBC_GT: rel_hit = rel_gt;
            PLCBC_GE: rel_hit = rel_gt | rel_eq;
            PLCBC_EQ: rel_hit = rel_eq;
            PLCBC_NE: rel_hit = !rel_eq;
            PLCBC_LT: rel_hit = rel_lt;
            PLCBC_LE: rel_hit = rel_lt | rel_eq;
            default:  rel_hit = 1'b0;
        endcase
    end

    // ===================================================
    // next state
    // ===================================================
    always_comb
    begin
        st_d           = st_q;
        st_d.done      = 1'b0;
        st_d.result_we = 1'b0;
        st_d.device_we = 1'b0;
        if (op_valid)
        begin
            st_d.done = 1'b1;
            if (instruction_code == OP_ROR1)
            begin
                st_d.result_we   = 1'b1;
                st_d.result_word = {src_lo[0], src_lo[WORD_W-1:1]};
                st_d.carry       = src_lo[0];
            end
            else if (instruction_code == OP_ROL1)
            begin
                st_d.result_we   = 1'b1;
                st_d.result_word = {src_lo[WORD_W-2:0], src_lo[WORD_W-1]};
                st_d.carry       = src_lo[WORD_W-1];
            end
            else if (instruction_code == OP_RORN)
            begin
                st_d.result_we   = 1'b1;
                st_d.result_word = ror_n;
                if (rot_count != '0)
                begin
                    st_d.carry = ror_n[WORD_W-1];
                end
            end
            else if (instruction_code == OP_ROLN)
            begin
                st_d.result_we   = 1'b1;
                st_d.result_word = rol_n;
                if (rot_count != '0)
                begin
                    st_d.carry = rol_n[0];
                end
            end
            else if (instruction_code >= OP_CMP_S
                     && instruction_code < OP_CMP_U + 8'(CMP_SPAN))
            begin
                st_d.rung_out = rung_in & rel_hit;
            end
            else if (instruction_code == OP_SET)
            begin
                st_d.result_we   = operand_is_word;
                st_d.device_we   = !operand_is_word;
                st_d.device_val  = 1'b1;
                st_d.result_word = WORD_ONES;
            end
            else if (instruction_code == OP_RST)
            begin
                st_d.result_we   = operand_is_word;
                st_d.device_we   = !operand_is_word;
                st_d.device_val  = 1'b0;
                st_d.result_word = WORD_ZERO;
            end
            else if (instruction_code == OP_CARRY_ON)
            begin
                st_d.carry = 1'b1;
            end
            else if (instruction_code == OP_CARRY_OFF)
            begin
                st_d.carry = 1'b0;
            end
            else if (instruction_code == OP_ENCODE)
            begin
                st_d.result_we   = 1'b1;
                st_d.result_word = top_bit_pos;
            end
            else if (instruction_code == OP_DECODE)
            begin
                st_d.result_we   = 1'b1;
                st_d.result_word = one_hot_word;
            end
            else if (instruction_code == OP_POPCNT)
            begin
                st_d.result_we   = 1'b1;
                st_d.result_word = WORD_W'(pop_ones);
            end
            else if (instruction_code == OP_FF)
            begin
                st_d.device_we = ff_set_in | ff_clr_in;
                if (ff_clr_in)
                begin
                    st_d.device_val = 1'b0;
                end
                else if (ff_set_in)
                begin
                    st_d.device_val = 1'b1;
                end
                st_d.rung_out = st_d.device_val;
            end
            else if (instruction_code == OP_UDC)
            begin
                st_d.pulse_prev = cnt_pulse_in;
                if (cnt_enable && cnt_pulse_in && !st_q.pulse_prev)
                begin
                    if (cnt_up)
                    begin
                        st_d.count_val = st_q.count_val + 16'h0001;
                    end
                    else
                    begin
                        st_d.count_val = st_q.count_val - 16'h0001;
                    end
                end
            end
        end
    end

    // ===================================================
    // registers
    // ===================================================
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign done        = st_q.done;
    assign result_we   = st_q.result_we;
    assign result_word = st_q.result_word;
    assign device_we   = st_q.device_we;
    assign device_val  = st_q.device_val;
    assign rung_out    = st_q.rung_out;
    assign carry       = st_q.carry;
    assign count_val   = st_q.count_val;
endmodule
`default_nettype wire

// >>> sim/plcbc_datapath_properties.sv
`timescale 1ns/100ps
`default_nettype none
module plcbc_datapath_properties
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // issue
    input wire logic        op_valid,
    input wire logic [7:0]  instruction_code,
    input wire logic        rung_in,
    input wire logic        operand_is_word,
    input wire logic [15:0] src_lo,
    input wire logic [15:0] ref_lo,
    input wire logic        ff_clr_in,
    input wire logic        cnt_enable,
    // results
    input wire logic        done,
    input wire logic        result_we,
    input wire logic [15:0] result_word,
    input wire logic        rung_out,
    input wire logic        carry,
    input wire logic [15:0] count_val
);
    import plcbc_pkg::*;
    // ========
    // checks, all on the one clock
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // an instruction taken at this edge
    sequence s_op(logic [7:0] c);
        op_valid && instruction_code == c;
    endsequence
    a_done_follows: assert property (op_valid |=> done)
        else $error("done missing after issue");
    // rotating the result back must give the operand again
    a_ror_one_wrap: assert property (s_op(OP_ROR1) |=>
        {result_word[14:0], result_word[15]} == $past(src_lo)
        && carry == result_word[15])
        else $error("single right rotate wrong");
    a_rol_one_wrap: assert property (s_op(OP_ROL1) |=>
        {result_word[0], result_word[15:1]} == $past(src_lo)
        && carry == result_word[0])
        else $error("single left rotate wrong");
    a_carry_set: assert property (s_op(OP_CARRY_ON) |=>
        carry && !result_we)
        else $error("set carry wrong");
    a_carry_clear: assert property (s_op(OP_CARRY_OFF) |=>
        !carry && !result_we)
        else $error("clear carry wrong");
    a_word_set: assert property (s_op(OP_SET) ##0 operand_is_word |=>
        result_we && result_word == WORD_ONES)
        else $error("word set wrong");
    a_word_reset: assert property (s_op(OP_RST) ##0 operand_is_word |=>
        result_we && result_word == WORD_ZERO)
        else $error("word reset wrong");
    a_unsigned_eq: assert property (s_op(OP_CMP_U + 8'h02) |=>
        rung_out == ($past(rung_in) && $past(src_lo) == $past(ref_lo)))
        else $error("unsigned equal wrong");
    a_clear_wins: assert property (s_op(OP_FF) ##0 ff_clr_in |=>
        !rung_out)
        else $error("latch not cleared");
    a_count_hold: assert property (s_op(OP_UDC) ##0 !cnt_enable |=>
        $stable(count_val))
        else $error("count moved while disabled");
endmodule
bind plcbc_datapath plcbc_datapath_properties i_props (.mclk, .reset_n,
    .op_valid, .instruction_code, .rung_in, .operand_is_word, .src_lo,
    .ref_lo, .ff_clr_in, .cnt_enable, .done, .result_we, .result_word,
    .rung_out, .carry, .count_val);
`default_nettype wire

// >>> sim/test_plc_bit_compare_datapath.sv
`timescale 1ns/100ps
`default_nettype none
module test_plc_bit_compare_datapath;
    import plcbc_pkg::*;
    // ========
    // stimulus and results
    logic        mclk, reset_n, op_valid, rung_in, operand_is_word;
    logic        ff_set_in, ff_clr_in, cnt_enable, cnt_pulse_in, cnt_up;
    logic        done, result_we, device_we, device_val, rung_out, carry;
    logic [7:0]  instruction_code;
    logic [15:0] src_lo, src_hi, ref_lo, ref_hi, result_word, count_val;
    logic [3:0]  rot_count;
    logic [2:0]  field_n;
    int          err_count, compares;

    plcbc_datapath i_plcbc_datapath (.mclk, .reset_n, .op_valid,
        .instruction_code, .rung_in, .operand_is_word, .src_lo, .src_hi,
        .ref_lo, .ref_hi, .rot_count, .field_n, .ff_set_in, .ff_clr_in,
        .cnt_enable, .cnt_pulse_in, .cnt_up, .done, .result_we,
        .result_word, .device_we, .device_val, .rung_out, .carry,
        .count_val);

    // ========
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // entered just after an edge; returns just after the answer edge;
    // request stays up so back-to-back issues never toggle it twice
    task automatic issue(input logic [7:0] code);
        instruction_code = code;
        op_valid = 1'b1;
        @(posedge mclk);
        #1;
        chk(done, 1'b1);
    endtask

    task automatic word_op(input logic [7:0] code, input logic [15:0] a,
                           input logic [3:0] n, input logic [15:0] ew);
        src_lo = a;
        rot_count = n;
        field_n = n[2:0];
        issue(code);
        chk(result_we, 1'b1);
        chk(result_word, ew);
    endtask

    function automatic logic rel(input int r, input logic lt, input logic eq);
        case (r)
            0: return !lt && !eq;
            1: return !lt;
            2: return eq;
            3: return !eq;
            4: return lt;
            default: return lt || eq;
        endcase
    endfunction

    // ========
    // scenarios
    task automatic t_rotate;
        word_op(OP_ROR1, 16'h0001, 4'h0, 16'h8000);
        chk(carry, 1'b1);
        word_op(OP_ROL1, 16'h8000, 4'h0, 16'h0001);
        chk(carry, 1'b1);
        word_op(OP_ROL1, 16'h4000, 4'h0, 16'h8000);
        chk(carry, 1'b0);
        word_op(OP_RORN, 16'h1234, 4'h4, 16'h4123);
        chk(carry, 1'b0);
        word_op(OP_ROLN, 16'h1234, 4'h4, 16'h2341);
        chk(carry, 1'b1);
        // largest count wraps almost all the way round
        word_op(OP_RORN, 16'h0001, 4'hf, 16'h0002);
        $display("rotate test done");
    endtask

    task automatic t_compare;
        logic lt_s, lt_d, lt_u, eq_w, eq_d;
        rung_in = 1'b1;
        // signed order disagrees with unsigned and double-word orders on the first pass; the second pass makes all three equal
        for (int p = 0; p < 2; p++)
        begin
            src_lo = 16'hffff;
            src_hi = 16'h0001;
            ref_lo = p ? 16'hffff : 16'h0001;
            ref_hi = p ? 16'h0001 : 16'h8000;
            lt_s = $signed(src_lo) < $signed(ref_lo);
            lt_u = src_lo < ref_lo;
            lt_d = $signed({src_hi, src_lo}) < $signed({ref_hi, ref_lo});
            eq_w = src_lo == ref_lo;
            eq_d = {src_hi, src_lo} == {ref_hi, ref_lo};
            for (int r = 0; r < 6; r++)
            begin
                issue(OP_CMP_S + 8'(r));
                chk(rung_out, rel(r, lt_s, eq_w));
                issue(OP_CMP_D + 8'(r));
                chk(rung_out, rel(r, lt_d, eq_d));
                issue(OP_CMP_U + 8'(r));
                chk(rung_out, rel(r, lt_u, eq_w));
            end
        end
        // no power on the rung, no output
        rung_in = 1'b0;
        issue(OP_CMP_U + 8'h02);
        chk(rung_out, 1'b0);
        $display("compare test done");
    endtask

    task automatic t_set_reset;
        operand_is_word = 1'b1;
        word_op(OP_SET, 16'h1234, 4'h0, WORD_ONES);
        word_op(OP_RST, 16'h1234, 4'h0, WORD_ZERO);
        operand_is_word = 1'b0;
        issue(OP_SET);
        chk({device_we, device_val, result_we}, 3'b110);
        issue(OP_RST);
        chk({device_we, device_val, result_we}, 3'b100);
        issue(OP_CARRY_ON);
        chk({carry, result_we, device_we}, 3'b100);
        issue(OP_CARRY_OFF);
        chk({carry, result_we, device_we}, 3'b000);
        $display("set and reset test done");
    endtask

    task automatic t_bits;
        word_op(OP_ENCODE, 16'h0500, 4'h4, 16'h000a);
        word_op(OP_ENCODE, 16'h8001, 4'h4, 16'h000f);
        word_op(OP_ENCODE, 16'h00ff, 4'h3, 16'h0007);
        word_op(OP_ENCODE, 16'h0500, 4'h3, 16'h0000);
        word_op(OP_DECODE, 16'h0005, 4'h4, 16'h0020);
        word_op(OP_DECODE, 16'hfff3, 4'h4, 16'h0008);
        word_op(OP_POPCNT, 16'hf0f1, 4'h0, 16'h0009);
        word_op(OP_POPCNT, 16'hffff, 4'h0, 16'h0010);
        $display("bit processing test done");
    endtask

    task automatic t_latch_count;
        logic [1:0]  sr [5] = '{2'b10, 2'b00, 2'b11, 2'b10, 2'b01};
        logic        q [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [2:0]  ctl [9] = '{3'b110, 3'b111, 3'b111, 3'b110, 3'b111,
                                 3'b010, 3'b011, 3'b100, 3'b101};
        logic [15:0] ce [9] = '{16'h0, 16'h1, 16'h1, 16'h1, 16'h2, 16'h2,
                                16'h2, 16'h2, 16'h1};
        for (int i = 0; i < 5; i++)
        begin
            {ff_set_in, ff_clr_in} = sr[i];
            issue(OP_FF);
            chk(rung_out, q[i]);
        end
        // enable, direction, count input; a held input steps only once
        for (int i = 0; i < 9; i++)
        begin
            {cnt_enable, cnt_up, cnt_pulse_in} = ctl[i];
            issue(OP_UDC);
            chk(count_val, ce[i]);
        end
        $display("latch and counter test done");
    endtask

    // ========
    // closing
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // clock, 20 ns period
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // main sequence
    initial
    begin
        {reset_n, op_valid, rung_in, operand_is_word, ff_set_in} = '0;
        {ff_clr_in, cnt_enable, cnt_pulse_in, cnt_up} = '0;
        {instruction_code, src_lo, src_hi, ref_lo, ref_hi} = '0;
        rot_count = '0;
        field_n = '0;
        err_count = 0;
        compares = 0;
        repeat (4) @(posedge mclk);
        #1 reset_n = 1'b1;
        t_rotate();
        t_compare();
        t_set_reset();
        t_bits();
        t_latch_count();
        report_and_stop();
    end

    // guard against a hang
    initial
    begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
